// ### hw/pcrb_regbank.sv
// Buffered register bank for the first-stage loop controls.
//
// Operation
// R1: Register 0x000B is a read-only protocol version, zero from reset, writes ignored.
// R2: A 16-bit read-only vendor code sits low byte at 0x000C and high byte at 0x000D.
// R3: Writing 1 to bit 0 of 0x000F copies every buffered value into the active controls.
// R4: That strobe bit clears itself; the host never writes it back to zero.
// R5: Bits 7:1 of the strobe register are reserved and read as zero.
// R6: Reference A pre-divider is 10 bits: low byte at 0x0100, bits 9:8 in 0x0101[1:0].
// R7: Reference B pre-divider is 10 bits: low byte at 0x0102, bits 9:8 in 0x0103[1:0].
// R8: Loop feedback divider is 10 bits: low byte at 0x0104, bits 9:8 in 0x0105[1:0].
// R9: Each divider divides by its value from 2 to 1023, and 0 or 1 both divide by one.
// R10: Bit 7 of 0x0106 tristates the charge pump to force holdover; clearing it restores it.
// R11: Bits 6:0 of 0x0106 set the charge pump current in steps of about 0.5 uA.
// R12: Bit 5 of 0x0107 at one disables automatic holdover, at zero allows it.
// R13: Bits 1:0 of 0x0107 pick the pump mode: tristate (reset), down, up, normal.
// R14: With the readback select bit set, buffered registers read pending values, else active.
// R15: Buffered writes change nothing until the strobe; the host strobes after divider writes.
`timescale 1ns/1ps
module pcrb_regbank #(
    // Arbitrary neutral identification value
    parameter logic [15:0] VENDOR_CODE = 16'ha5c3
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register access from the serial port engine
    input wire pcrb_pkg::pcrb_req_t req_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    // Loop status and reference ticks
    input wire logic loss_of_ref_in,
    input wire logic [pcrb_pkg::NUM_DIV-1:0] div_tick_in,
    // Active controls towards the loop
    output pcrb_pkg::pcrb_ctrl_t active_ctrl_out,
    output logic [pcrb_pkg::NUM_DIV-1:0] div_tick_out,
    output logic holdover_out,
    output logic pump_tristate_out,
    output logic pump_up_out,
    output logic pump_down_out,
    output logic transfer_pulse_out
);
    import pcrb_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pcrb_ctrl_t buf_ff;
    pcrb_ctrl_t nxt_buf;
    pcrb_ctrl_t act_ff;
    pcrb_ctrl_t nxt_act;
    logic readback_sel_ff;
    logic nxt_readback_sel;
    logic transfer_ff;
    logic nxt_transfer;
    logic [7:0] rd_data_ff;
    logic [7:0] nxt_rd_data;
    logic rd_valid_ff;
    logic nxt_rd_valid;
    pcrb_ctrl_t view;
    logic [DIV_W-1:0] div_val [NUM_DIV];

    // Byte view of one control set at a buffered address; reserved bits read zero
    function automatic logic [7:0] ctrl_byte(input pcrb_ctrl_t c, input logic [15:0] a);
        logic [7:0] b;
        b = READ_ZERO;
        unique case (a)
            ADDR_REF_A_PREDIV_LOW: b = c.ref_a_div[7:0]; // see R6
            ADDR_REF_A_PREDIV_HIGH: b[DIV_HIGH_MSB:0] = c.ref_a_div[9:8]; // see R6
            ADDR_REF_B_PREDIV_LOW: b = c.ref_b_div[7:0]; // see R7
            ADDR_REF_B_PREDIV_HIGH: b[DIV_HIGH_MSB:0] = c.ref_b_div[9:8]; // see R7
            ADDR_LOOP_FEEDBACK_DIV_LOW: b = c.fb_div[7:0]; // see R8
            ADDR_LOOP_FEEDBACK_DIV_HIGH: b[DIV_HIGH_MSB:0] = c.fb_div[9:8]; // see R8
            ADDR_PUMP_CURRENT_HOLDOVER: begin
                b[FORCE_HOLDOVER_BIT] = c.force_holdover; // see R10
                b[PUMP_CURRENT_MSB:0] = c.pump_current; // see R11
            end
            ADDR_PUMP_MODE_HOLDOVER_CTL: begin
                b[HOLDOVER_DISABLE_BIT] = c.holdover_disable; // see R12
                b[PUMP_MODE_MSB:0] = c.pump_mode; // see R13
            end
            default: b = READ_ZERO;
        endcase
        return b;
    endfunction

    // ------------------------------------------------------------------
    // Write path: buffered copy, readback select, transfer strobe
    // ------------------------------------------------------------------
    // Writes land only in the buffered copy so a half-written divider never
    // reaches the loop; the active copy moves only on the strobe
    always_comb begin
        nxt_buf = buf_ff;
        nxt_readback_sel = readback_sel_ff;
        nxt_transfer = 1'b0; // see R4
        if (req_in.wr) begin
            unique case (req_in.addr)
                ADDR_CONFIG_B: nxt_readback_sel = req_in.wdata[READBACK_SEL_BIT];
                ADDR_BUFFER_TRANSFER_STROBE:
                    nxt_transfer = req_in.wdata[TRANSFER_BIT]; // see R3
                ADDR_REF_A_PREDIV_LOW: nxt_buf.ref_a_div[7:0] = req_in.wdata; // see R6
                ADDR_REF_A_PREDIV_HIGH:
                    nxt_buf.ref_a_div[9:8] = req_in.wdata[DIV_HIGH_MSB:0]; // see R6
                ADDR_REF_B_PREDIV_LOW: nxt_buf.ref_b_div[7:0] = req_in.wdata; // see R7
                ADDR_REF_B_PREDIV_HIGH:
                    nxt_buf.ref_b_div[9:8] = req_in.wdata[DIV_HIGH_MSB:0]; // see R7
                ADDR_LOOP_FEEDBACK_DIV_LOW: nxt_buf.fb_div[7:0] = req_in.wdata; // see R8
                ADDR_LOOP_FEEDBACK_DIV_HIGH:
                    nxt_buf.fb_div[9:8] = req_in.wdata[DIV_HIGH_MSB:0]; // see R8
                ADDR_PUMP_CURRENT_HOLDOVER: begin
                    nxt_buf.force_holdover = req_in.wdata[FORCE_HOLDOVER_BIT]; // see R10
                    nxt_buf.pump_current = req_in.wdata[PUMP_CURRENT_MSB:0]; // see R11
                end
                ADDR_PUMP_MODE_HOLDOVER_CTL: begin
                    nxt_buf.holdover_disable = req_in.wdata[HOLDOVER_DISABLE_BIT]; // see R12
                    nxt_buf.pump_mode =
                        pcrb_pump_mode_t'(req_in.wdata[PUMP_MODE_MSB:0]); // see R13
                end
                // Identification registers and unmapped addresses drop the write
                default: nxt_buf = buf_ff; // see R1
            endcase
        end
    end

    // Active copy follows the buffered copy one edge after the strobe write
    always_comb begin
        nxt_act = act_ff; // see R15
        if (transfer_ff) begin
            nxt_act = buf_ff; // see R3
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Readback select picks which copy the buffered addresses show
    always_comb begin
        view = readback_sel_ff ? buf_ff : act_ff; // see R14
        nxt_rd_valid = req_in.rd;
        nxt_rd_data = rd_data_ff;
        if (req_in.rd) begin
            unique case (req_in.addr)
                ADDR_CONFIG_B: begin
                    nxt_rd_data = READ_ZERO;
                    nxt_rd_data[READBACK_SEL_BIT] = readback_sel_ff;
                end
                ADDR_PROTOCOL_VERSION: nxt_rd_data = PROTOCOL_VERSION_RST; // see R1
                ADDR_VENDOR_CODE_LOW: nxt_rd_data = VENDOR_CODE[7:0]; // see R2
                ADDR_VENDOR_CODE_HIGH: nxt_rd_data = VENDOR_CODE[15:8]; // see R2
                // Strobe bit is gone by the time a read can see it
                ADDR_BUFFER_TRANSFER_STROBE: nxt_rd_data = READ_ZERO; // see R5
                default: nxt_rd_data = ctrl_byte(view, req_in.addr);
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            buf_ff <= CTRL_RST;
            act_ff <= CTRL_RST; // see R13
            readback_sel_ff <= READBACK_SEL_RST;
            transfer_ff <= 1'b0;
            rd_data_ff <= READ_ZERO;
            rd_valid_ff <= 1'b0;
        end else begin
            buf_ff <= nxt_buf;
            act_ff <= nxt_act;
            readback_sel_ff <= nxt_readback_sel;
            transfer_ff <= nxt_transfer;
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    // ------------------------------------------------------------------
    // Dividers driven by the active ratios
    // ------------------------------------------------------------------
    assign div_val[0] = act_ff.ref_a_div;
    assign div_val[1] = act_ff.ref_b_div;
    assign div_val[2] = act_ff.fb_div;

    for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
        pcrb_divider u_div (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .tick_in(div_tick_in[i]),
            .div_val_in(div_val[i]),
            .tick_out(div_tick_out[i])
        ); // see R9
    end

    // ------------------------------------------------------------------
    // Holdover and charge pump steering
    // ------------------------------------------------------------------
    // Forced holdover wins; automatic entry only while not disabled
    assign holdover_out = act_ff.force_holdover |
        (loss_of_ref_in & ~act_ff.holdover_disable); // see R10 R12
    // Holdover and mode 00 both leave the pump tristated
    assign pump_tristate_out = holdover_out |
        (act_ff.pump_mode == PCRB_PUMP_TRISTATE); // see R10 R13
    assign pump_up_out = ~holdover_out & (act_ff.pump_mode == PCRB_PUMP_UP); // see R13
    assign pump_down_out = ~holdover_out & (act_ff.pump_mode == PCRB_PUMP_DOWN); // see R13

    assign active_ctrl_out = act_ff;
    assign rd_data_out = rd_data_ff;
    assign rd_valid_out = rd_valid_ff;
    assign transfer_pulse_out = transfer_ff;

endmodule

// ### hw/pcrb_pkg.sv
// Package for the loop configuration register bank: map, fields, resets, carriers.
package pcrb_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_CONFIG_B = 16'h0001;
    localparam logic [15:0] ADDR_PROTOCOL_VERSION = 16'h000b;
    localparam logic [15:0] ADDR_VENDOR_CODE_LOW = 16'h000c;
    localparam logic [15:0] ADDR_VENDOR_CODE_HIGH = 16'h000d;
    localparam logic [15:0] ADDR_BUFFER_TRANSFER_STROBE = 16'h000f;
    localparam logic [15:0] ADDR_REF_A_PREDIV_LOW = 16'h0100;
    localparam logic [15:0] ADDR_REF_A_PREDIV_HIGH = 16'h0101;
    localparam logic [15:0] ADDR_REF_B_PREDIV_LOW = 16'h0102;
    localparam logic [15:0] ADDR_REF_B_PREDIV_HIGH = 16'h0103;
    localparam logic [15:0] ADDR_LOOP_FEEDBACK_DIV_LOW = 16'h0104;
    localparam logic [15:0] ADDR_LOOP_FEEDBACK_DIV_HIGH = 16'h0105;
    localparam logic [15:0] ADDR_PUMP_CURRENT_HOLDOVER = 16'h0106;
    localparam logic [15:0] ADDR_PUMP_MODE_HOLDOVER_CTL = 16'h0107;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int READBACK_SEL_BIT = 3;
    localparam int TRANSFER_BIT = 0;
    localparam int DIV_HIGH_MSB = 1;
    localparam int FORCE_HOLDOVER_BIT = 7;
    localparam int PUMP_CURRENT_MSB = 6;
    localparam int HOLDOVER_DISABLE_BIT = 5;
    localparam int PUMP_MODE_MSB = 1;

    // ------------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------------
    localparam logic [7:0] PROTOCOL_VERSION_RST = 8'h00;
    localparam logic [9:0] DIV_RST = 10'h000;
    localparam logic [6:0] PUMP_CURRENT_RST = 7'h00;
    localparam logic READBACK_SEL_RST = 1'b0;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam int DIV_W = 10;
    localparam int NUM_DIV = 3;

    // Charge pump mode encodings
    typedef enum logic [1:0] {
        PCRB_PUMP_TRISTATE = 2'b00,
        PCRB_PUMP_DOWN = 2'b01,
        PCRB_PUMP_UP = 2'b10,
        PCRB_PUMP_NORMAL = 2'b11
    } pcrb_pump_mode_t;

    // Register access request from the serial port engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } pcrb_req_t;

    // One full set of loop controls, used for the buffered and the active copy
    typedef struct packed {
        logic [9:0] ref_a_div;
        logic [9:0] ref_b_div;
        logic [9:0] fb_div;
        logic force_holdover;
        logic [6:0] pump_current;
        logic holdover_disable;
        pcrb_pump_mode_t pump_mode;
    } pcrb_ctrl_t;

    localparam pcrb_ctrl_t CTRL_RST = '{
        ref_a_div: DIV_RST,
        ref_b_div: DIV_RST,
        fb_div: DIV_RST,
        force_holdover: 1'b0,
        pump_current: PUMP_CURRENT_RST,
        holdover_disable: 1'b0,
        pump_mode: PCRB_PUMP_TRISTATE
    };

endpackage

// ### hw/pcrb_divider.sv
// Programmable tick divider, one per reference or feedback path.
`timescale 1ns/1ps
module pcrb_divider (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Input ticks and ratio
    input wire logic tick_in,
    input wire logic [pcrb_pkg::DIV_W-1:0] div_val_in,
    // Divided ticks
    output logic tick_out
);
    import pcrb_pkg::*;

    logic [DIV_W-1:0] count_ff;
    logic [DIV_W-1:0] nxt_count;
    logic tick_ff;
    logic nxt_tick;
    logic [DIV_W-1:0] last_count;

    // ------------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------------
    // Ratios 0 and 1 both give the terminal count zero: divide by one
    always_comb begin
        if (div_val_in <= DIV_W'(1)) begin
            last_count = '0;
        end else begin
            last_count = div_val_in - DIV_W'(1);
        end
        nxt_count = count_ff;
        nxt_tick = 1'b0;
        if (tick_in) begin
            // A ratio lowered below the count wraps at once, never runs to 1023
            if (count_ff >= last_count) begin // see R9
                nxt_count = '0;
                nxt_tick = 1'b1;
            end else begin
                nxt_count = count_ff + DIV_W'(1);
            end
        end
    end

    // Registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_out = tick_ff;

endmodule

// ### dv/pcrb_regbank_properties.sv
// Port checker for the loop configuration register bank.
`timescale 1ns/1ps
module pcrb_regbank_properties #(
    // Arbitrary neutral identification value, overridden by the bind
    parameter logic [15:0] VENDOR_CODE = 16'ha5c3
) (
    // Clock, reset and register port
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire pcrb_pkg::pcrb_req_t req_in,
    input wire logic [7:0] rd_data_out,
    input wire logic rd_valid_out,
    // Loop side
    input wire logic loss_of_ref_in,
    input wire logic [pcrb_pkg::NUM_DIV-1:0] div_tick_in,
    input wire pcrb_pkg::pcrb_ctrl_t active_ctrl_out,
    input wire logic [pcrb_pkg::NUM_DIV-1:0] div_tick_out,
    input wire logic holdover_out,
    input wire logic pump_tristate_out,
    input wire logic pump_up_out,
    input wire logic pump_down_out,
    input wire logic transfer_pulse_out
);
    import pcrb_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Decoded request kinds
    wire [15:0] a = req_in.addr;
    wire strb = req_in.wr && a == ADDR_BUFFER_TRANSFER_STROBE && req_in.wdata[0];
    wire [1:0] md = active_ctrl_out.pump_mode;
    read_answer_a: assert property (
        req_in.rd |=> rd_valid_out) else $error("read not answered");
    version_zero_a: assert property (
        req_in.rd && a == ADDR_PROTOCOL_VERSION |=> rd_data_out == 8'h00)
        else $error("version not zero");
    vendor_low_a: assert property (
        req_in.rd && a == ADDR_VENDOR_CODE_LOW |=> rd_data_out == VENDOR_CODE[7:0])
        else $error("vendor low wrong");
    vendor_high_a: assert property (
        req_in.rd && a == ADDR_VENDOR_CODE_HIGH |=> rd_data_out == VENDOR_CODE[15:8])
        else $error("vendor high wrong");
    strobe_fires_a: assert property (
        strb |=> transfer_pulse_out) else $error("strobe lost");
    strobe_clears_a: assert property (
        transfer_pulse_out |-> $past(strb)) else $error("pulse without strobe");
    strobe_reads_zero_a: assert property (
        req_in.rd && a == ADDR_BUFFER_TRANSFER_STROBE |=> rd_data_out == 8'h00)
        else $error("strobe register not zero");
    active_hold_a: assert property (
        !$past(transfer_pulse_out) |-> $stable(active_ctrl_out)) else $error("early apply");
    holdover_law_a: assert property (
        holdover_out == (active_ctrl_out.force_holdover
        || loss_of_ref_in && !active_ctrl_out.holdover_disable)) else $error("holdover wrong");
    pump_mode_a: assert property (
        {pump_tristate_out, pump_up_out, pump_down_out} == {holdover_out || md == 2'b00,
        !holdover_out && md == 2'b10, !holdover_out && md == 2'b01}) else $error("pump wrong");
    div_by_one_a: assert property (
        active_ctrl_out.ref_b_div <= 10'h001 && div_tick_in[1] |=> div_tick_out[1])
        else $error("divide by one missed");
    // Main scenarios reached
    strobe_c: cover property (transfer_pulse_out);
    lost_ref_c: cover property (loss_of_ref_in && holdover_out);
    fb_tick_c: cover property (div_tick_out[2]);
endmodule

bind pcrb_regbank pcrb_regbank_properties #(.VENDOR_CODE(VENDOR_CODE))
    pcrb_regbank_properties_i (.*);

// ### dv/pcrb_host_model.sv
// Serial port host model that issues register requests to the bank.
`timescale 1ns/1ps
module pcrb_host_model (
    // Clock and read answer
    input wire logic clk_in,
    input wire logic rd_valid_in,
    input wire logic [7:0] rd_data_in,
    // Requests towards the bank
    output pcrb_pkg::pcrb_req_t req_out
);
    import pcrb_pkg::*;
    initial req_out = '0;
    // Idle lines show inverted leftovers so stale values never pass as live
    task automatic idle();
        req_out.wr = 1'b0;
        req_out.rd = 1'b0;
        req_out.addr = ~req_out.addr;
        req_out.wdata = ~req_out.wdata;
    endtask
    // One request, held until the taking edge
    task automatic write_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_in);
        #1;
        idle();
    endtask
    task automatic read_reg(input logic [15:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_in);
        #1;
        req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_in);
        #1;
        idle();
        ok = 1'b0;
        d = 8'h00;
        // Bounded wait so a silent bank cannot hang the host
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rd_valid_in === 1'b1) begin
                ok = 1'b1;
                d = rd_data_in;
            end else begin
                @(posedge clk_in);
                #1;
            end
        end
    endtask
    // Divider is written low byte first; the strobe follows the pair when asked
    task automatic write_div(input logic [15:0] lo, input logic [9:0] v, input logic go);
        write_reg(lo, v[7:0]);
        write_reg(lo + 16'h0001, {6'h00, v[9:8]});
        if (go) begin
            write_reg(ADDR_BUFFER_TRANSFER_STROBE, 8'h01);
        end
    endtask
endmodule

// ### dv/pcrb_regbank_bench.sv
// Self-checking bench for the loop configuration register bank.
`timescale 1ns/1ps
module pcrb_regbank_bench;
    import pcrb_pkg::*;
    localparam logic [15:0] VCODE = 16'h3c5a; // Arbitrary neutral vendor value
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic loss_of_ref_in = 1'b0;
    logic [NUM_DIV-1:0] div_tick_in = '0;
    pcrb_req_t req;
    pcrb_ctrl_t act;
    logic [7:0] rd_data;
    logic rd_valid, hold, p_tri, p_up, p_dn, xfer;
    logic [NUM_DIV-1:0] tick_o;
    int err_count = 0;
    int n_checks = 0;
    // 125 MHz clock
    always #4 clk_in = ~clk_in;
    pcrb_regbank #(.VENDOR_CODE(VCODE)) pcrb_regbank_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .req_in(req), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .loss_of_ref_in(loss_of_ref_in), .div_tick_in(div_tick_in), .active_ctrl_out(act),
        .div_tick_out(tick_o), .holdover_out(hold), .pump_tristate_out(p_tri),
        .pump_up_out(p_up), .pump_down_out(p_dn), .transfer_pulse_out(xfer));
    pcrb_host_model pcrb_host_model_i (.clk_in(clk_in), .rd_valid_in(rd_valid),
        .rd_data_in(rd_data), .req_out(req));
    // Shared comparison, verdict and bus helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        pcrb_host_model_i.write_reg(a, d);
    endtask
    task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        pcrb_host_model_i.read_reg(a, d, ok);
        if (ok !== 1'b1) begin
            err_count++;
            close_out();
        end
        check(what, 16'(d), 16'(exp));
    endtask
    // Strobe write, then the pulse must come once and go; it stands only in the
    // cycle right after the taking edge, so it is looked at as the write returns
    task automatic strobe(input logic [7:0] d);
        wr(ADDR_BUFFER_TRANSFER_STROBE, d);
        check("pulse", 16'(xfer), 16'(d[0]));
        @(posedge clk_in);
        #1;
        check("pulse clear", 16'(xfer), 16'h0000);
    endtask
    task automatic t_reset();
        check("tristate", 16'(p_tri), 16'h0001);
        rd_chk("version", ADDR_PROTOCOL_VERSION, 8'h00);
        rd_chk("strobe reg", ADDR_BUFFER_TRANSFER_STROBE, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rd_chk("ctl reset", ADDR_REF_A_PREDIV_LOW + 16'(i), 8'h00);
        end
        $display("done reset");
    endtask
    // Identity registers ignore writes; unmapped space reads zero
    task automatic t_ident();
        wr(ADDR_PROTOCOL_VERSION, 8'hff);
        wr(ADDR_VENDOR_CODE_LOW, 8'h00);
        rd_chk("version", ADDR_PROTOCOL_VERSION, 8'h00);
        rd_chk("vendor lo", ADDR_VENDOR_CODE_LOW, VCODE[7:0]);
        rd_chk("vendor hi", ADDR_VENDOR_CODE_HIGH, VCODE[15:8]);
        rd_chk("unmapped", 16'h0200, 8'h00);
        $display("done ident");
    endtask
    // Buffered divider writes stay pending until a real strobe
    task automatic t_buffer();
        wr(ADDR_CONFIG_B, 8'h08);
        pcrb_host_model_i.write_div(ADDR_REF_A_PREDIV_LOW, 10'h3ff, 1'b0);
        pcrb_host_model_i.write_div(ADDR_REF_B_PREDIV_LOW, 10'h001, 1'b0);
        pcrb_host_model_i.write_div(ADDR_LOOP_FEEDBACK_DIV_LOW, 10'h003, 1'b0);
        check("no early", 16'(act !== CTRL_RST), 16'h0000);
        rd_chk("buf a hi", ADDR_REF_A_PREDIV_HIGH, 8'h03);
        rd_chk("buf b lo", ADDR_REF_B_PREDIV_LOW, 8'h01);
        rd_chk("buf fb lo", ADDR_LOOP_FEEDBACK_DIV_LOW, 8'h03);
        wr(ADDR_CONFIG_B, 8'h00);
        rd_chk("act a lo", ADDR_REF_A_PREDIV_LOW, 8'h00);
        strobe(8'hfe);
        check("no apply", 16'(act !== CTRL_RST), 16'h0000);
        strobe(8'h01);
        check("a div", 16'(act.ref_a_div), 16'h03ff);
        check("b div", 16'(act.ref_b_div), 16'h0001);
        check("fb div", 16'(act.fb_div), 16'h0003);
        rd_chk("act a hi", ADDR_REF_A_PREDIV_HIGH, 8'h03);
        rd_chk("strobe reg", ADDR_BUFFER_TRANSFER_STROBE, 8'h00);
        $display("done buffer");
    endtask
    // Every pump mode, with forced and automatic holdover on a lost reference
    task automatic t_pump();
        logic f;
        logic dis;
        logic h;
        logic [1:0] m;
        loss_of_ref_in = 1'b1;
        for (int i = 0; i < 8; i++) begin
            f = i[2];
            m = i[1:0];
            dis = i[0];
            wr(ADDR_PUMP_CURRENT_HOLDOVER, {f, 7'h55});
            wr(ADDR_PUMP_MODE_HOLDOVER_CTL, {2'b11, dis, 3'b111, m});
            strobe(8'h01);
            h = f | ~dis;
            check("holdover", 16'(hold), 16'(h));
            check("pump", 16'({p_tri, p_up, p_dn}),
                16'({h | m == 2'b00, ~h & m == 2'b10, ~h & m == 2'b01}));
            check("current", 16'(act.pump_current), 16'h0055);
        end
        rd_chk("mode rd", ADDR_PUMP_MODE_HOLDOVER_CTL, 8'h23);
        rd_chk("pump rd", ADDR_PUMP_CURRENT_HOLDOVER, 8'hd5);
        loss_of_ref_in = 1'b0;
        $display("done pump");
    endtask
    // Nine ticks on each path: ratios 1023, 1 and 3
    task automatic t_divide();
        int cnt [NUM_DIV];
        cnt = '{default: 0};
        pcrb_host_model_i.write_div(ADDR_LOOP_FEEDBACK_DIV_LOW, 10'h003, 1'b1);
        repeat (9) begin
            @(posedge clk_in);
            #1;
            div_tick_in = '1;
            for (int k = 0; k < NUM_DIV; k++) cnt[k] += int'(tick_o[k]);
            @(posedge clk_in);
            #1;
            div_tick_in = '0;
            for (int k = 0; k < NUM_DIV; k++) cnt[k] += int'(tick_o[k]);
        end
        check("div a", 16'(cnt[0]), 16'h0000);
        check("div b", 16'(cnt[1]), 16'h0009);
        check("div fb", 16'(cnt[2]), 16'h0003);
        $display("done divide");
    endtask
    // Reset, then the scenarios in turn
    initial begin
        repeat (12) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        t_reset();
        t_ident();
        t_buffer();
        t_pump();
        t_divide();
        close_out();
    end
endmodule
